// >>> include/pwm_pkg.sv
// Package of constants and types for the complementary PWM generator
`default_nettype none
package pwm_pkg;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int  CLK_PERIOD_PS      = 5000;
   localparam int  DT_PRESCALE        = 8;
   localparam int  DT_TICK_PS         = 735;
   localparam int  DT_RISE_TICKS      = 75;
   localparam int  DT_FALL_TICKS      = 200;
   // Dead times are least times: round the tick total up to whole clock cycles
   localparam int  DT_RISE_CYC =
      (DT_RISE_TICKS * DT_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int  DT_FALL_CYC =
      (DT_FALL_TICKS * DT_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int  SW_FREQ_KHZ        = 200;
   localparam int  PERIOD_CYC         = 1000000000 / (SW_FREQ_KHZ * CLK_PERIOD_PS);
   localparam int  DUTY_PERCENT       = 66;
   localparam int  DUTY_CYC           = PERIOD_CYC * DUTY_PERCENT / 100;
   localparam int  CNT_W              = 16;

   // ****************************************************
   // Registers
   // ****************************************************
   localparam logic [3:0]  ADDR_CTRL     = 4'h0;
   localparam logic [3:0]  ADDR_STATUS   = 4'h4;
   localparam logic [3:0]  ADDR_PERIOD   = 4'h8;
   localparam logic [3:0]  ADDR_DUTY     = 4'hC;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          STAT_HS_BIT   = 0;
   localparam int          STAT_LS_BIT   = 1;
   localparam int          STAT_RUN_BIT  = 2;
   localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_BEEF;

   typedef enum {ST_OFF, ST_DT_RISE, ST_HIGH, ST_DT_FALL, ST_LOW} phase_t;

   typedef struct packed {
      logic hs;
      logic ls;
   } gate_t;
endpackage
`default_nettype wire

// >>> src/pwm_deadtime.sv
// Complementary PWM generator with dead time, Avalon-MM register slave
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`default_nettype none
module pwm_deadtime
   import pwm_pkg::*;
#(
   parameter int  DT_RISE = DT_RISE_CYC,
   parameter int  DT_FALL = DT_FALL_CYC
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   output logic                    high_side_switch_drive,
   output logic                    low_side_switch_drive
);

   // ****************************************************
   // Register file
   // ****************************************************
   logic             en_r, en_nxt;
   logic [CNT_W-1:0] period_r, period_nxt;
   logic [CNT_W-1:0] duty_r, duty_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             wait_r, wait_nxt;
   gate_t            gate_r, gate_nxt;
   phase_t           phase_r, phase_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] dt_r, dt_nxt;
   logic             pwm_ref;
   logic             acc;

   // One wait cycle per access: request taken when waitrequest is low
   assign acc = (avs_read | avs_write) & ~wait_r;

   always_comb begin
      en_nxt     = en_r;
      period_nxt = period_r;
      duty_nxt   = duty_r;
      rdata_nxt  = rdata_r;
      wait_nxt   = 1'b1;
      if (acc) begin
         wait_nxt = 1'b1;
      end else if (avs_read | avs_write) begin
         wait_nxt = 1'b0;
      end
      // Writes land at the edge where the master sees waitrequest low
      if (acc && avs_write) begin
         unique case (avs_address)
            ADDR_CTRL: begin
               if (avs_byteenable[0]) en_nxt = avs_writedata[CTRL_EN_BIT];
            end
            // Duty and period are static while running, so the compare
            // value stays fixed in open loop and only software changes it
            ADDR_PERIOD: begin
               if (!en_r && avs_byteenable[1:0] == 2'b11)
                  period_nxt = avs_writedata[CNT_W-1:0];
            end
            ADDR_DUTY: begin
               if (!en_r && avs_byteenable[1:0] == 2'b11)
                  duty_nxt = avs_writedata[CNT_W-1:0];
            end
            default: ;
         endcase
      end
      // Read data is fetched during the wait cycle so it stands at the answer edge
      if (avs_read && wait_r) begin
         unique case (avs_address)
            ADDR_CTRL:   rdata_nxt = {31'h0000_0000, en_r};
            ADDR_STATUS: rdata_nxt = {29'h0000_0000, (phase_r != ST_OFF),
                                      gate_r.ls, gate_r.hs};
            ADDR_PERIOD: rdata_nxt = {16'h0000, period_r};
            ADDR_DUTY:   rdata_nxt = {16'h0000, duty_r};
            default:     rdata_nxt = UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         en_r     <= 1'b0;
         period_r <= CNT_W'(PERIOD_CYC);
         duty_r   <= CNT_W'(DUTY_CYC);
         rdata_r  <= 32'h0000_0000;
         wait_r   <= 1'b1;
      end else begin
         en_r     <= en_nxt;
         period_r <= period_nxt;
         duty_r   <= duty_nxt;
         rdata_r  <= rdata_nxt;
         wait_r   <= wait_nxt;
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   // ****************************************************
   // Period counter and compare
   // ****************************************************
   always_comb begin
      cnt_nxt = cnt_r;
      if (!en_r || cnt_r >= period_r - 16'h0001) begin
         cnt_nxt = 16'h0000;
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end
   // Reference high from period start until counter reaches duty
   assign pwm_ref = en_r && (cnt_r < duty_r);

   // ****************************************************
   // Dead-time insertion
   // ****************************************************
   // Dead time runs in clock cycles: 8x kernel ticks of 0.735 ns are
   // rounded up to 5 ns cycles, so gaps are never shorter than set, except when enable is written back soon after a disable
   always_comb begin
      phase_nxt = phase_r;
      dt_nxt    = dt_r;
      gate_nxt  = '{hs: 1'b0, ls: 1'b0};
      if (dt_r != 16'h0000) dt_nxt = dt_r - 16'h0001;
      unique case (phase_r)
         ST_OFF: begin
            // Start with the low side on, so the first high-side rise also
            // follows a low-side fall and a full rising dead time
            if (en_r) begin
               phase_nxt   = ST_LOW;
               gate_nxt.ls = 1'b1;
            end
         end
         ST_LOW: begin
            gate_nxt.ls = 1'b1;
            if (!en_r) begin
               phase_nxt = ST_OFF;
               gate_nxt.ls = 1'b0;
            end else if (pwm_ref) begin
               gate_nxt.ls = 1'b0;
               phase_nxt   = ST_DT_RISE;
               dt_nxt      = CNT_W'(DT_RISE - 1);
            end
         end
         ST_DT_RISE: begin
            if (!en_r) phase_nxt = ST_OFF;
            else if (dt_r == 16'h0000) begin
               phase_nxt = ST_HIGH;
               gate_nxt.hs = 1'b1;
            end
         end
         ST_HIGH: begin
            gate_nxt.hs = 1'b1;
            if (!en_r || !pwm_ref) begin
               gate_nxt.hs = 1'b0;
               phase_nxt   = en_r ? ST_DT_FALL : ST_OFF;
               dt_nxt      = CNT_W'(DT_FALL - 1);
            end
         end
         ST_DT_FALL: begin
            if (!en_r) phase_nxt = ST_OFF;
            else if (dt_r == 16'h0000) begin
               phase_nxt = ST_LOW;
               gate_nxt.ls = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_r <= ST_OFF;
         dt_r    <= 16'h0000;
         cnt_r   <= 16'h0000;
         gate_r  <= '{hs: 1'b0, ls: 1'b0};
      end else begin
         phase_r <= phase_nxt;
         dt_r    <= dt_nxt;
         cnt_r   <= cnt_nxt;
         gate_r  <= gate_nxt;
      end
   end

   assign high_side_switch_drive = gate_r.hs;
   assign low_side_switch_drive  = gate_r.ls;

endmodule
`default_nettype wire

// >>> testbench/gate_driver_model.sv
// Half-bridge gate driver model that counts shoot-through cycles
`default_nettype none
module gate_driver_model
   import pwm_pkg::*;
(
   input  wire logic        clk,
   input  wire gate_t       g,
   output var logic [15:0]  shoot_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial shoot_cnt = 16'h0000;
   always @(posedge clk) if (g.hs && g.ls) shoot_cnt <= shoot_cnt + 16'h0001;
endmodule
`default_nettype wire

// >>> testbench/pwm_deadtime_chk.sv
// Assertion checker for the complementary PWM generator
`default_nettype none
module pwm_deadtime_chk
   import pwm_pkg::*;
#(
   parameter int DT_RISE = 1,
   parameter int DT_FALL = 1
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        high_side_switch_drive,
   input wire logic        low_side_switch_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic        hs = high_side_switch_drive;
   wire logic        ls = low_side_switch_drive;
   logic      [15:0] gap_r;
   logic      [15:0] gap_nxt;
   // Counts cycles with both switches off
   always_comb gap_nxt = (hs | ls) ? 16'h0000 : gap_r + 16'h0001;
   always_ff @(posedge clk) gap_r <= srst ? 16'h0000 : gap_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_no_overlap: assert property (!(hs && ls)) else $error("both drives high");
   a_rise_gap: assert property ($rose(hs) |-> gap_r == DT_RISE)
      else $error("rising dead time wrong");
   a_fall_gap: assert property ($rose(ls) |-> gap_r >= DT_FALL)
      else $error("falling dead time short");
   a_reset_quiet: assert property ($past(srst) |-> !hs && !ls)
      else $error("drive active after reset");
   a_wait_one: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
      else $error("answer late");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   a_unmapped_read: assert property (avs_read && !avs_waitrequest && avs_address == 4'h2
      |-> avs_readdata == UNMAPPED_DATA) else $error("unmapped read data");
   cover property ($rose(hs));
   cover property ($rose(ls));
   cover property (avs_write && !avs_waitrequest);
endmodule
bind pwm_deadtime pwm_deadtime_chk #(.DT_RISE(DT_RISE), .DT_FALL(DT_FALL)) chk_inst (.*);
`default_nettype wire

// >>> testbench/tb_pwm_deadtime.sv
// Self-checking bench for the complementary PWM generator
`default_nettype none
module tb_pwm_deadtime;
   import pwm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DR = 4, DF = 6, PER = 60;
   logic        clk = 0, srst = 1, rd = 0, wr = 0, p;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000, rdat, q;
   logic        wt, hs, ls;
   logic [15:0] sc;
   int          miscompares = 0, n_compared = 0, seed = 78122, m[4], duty, nh, nl, nr;
   pwm_deadtime #(.DT_RISE(DR), .DT_FALL(DF)) pwm_deadtime_inst (.clk(clk), .srst(srst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt),
      .high_side_switch_drive(hs), .low_side_switch_drive(ls));
   gate_driver_model gate_driver_model_inst (.clk(clk), .g({hs, ls}), .shoot_cnt(sc));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One Avalon access; waits for waitrequest low under a bound
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wt === 1'b0) break;
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 20) begin
         miscompares++;
         end_of_test;
      end
      if (w && a[3] && m[0] == 0) m[a[3:2]] = d[15:0];
      if (w && a == ADDR_CTRL) m[0] = d[0];
      if (!w) chk("register", q, a[1] ? UNMAPPED_DATA : m[a[3:2]]);
   endtask
   initial begin
      m = '{0, 0, PERIOD_CYC, DUTY_CYC};
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 16; a += 2) bus(1'b0, a[3:0], 32'h0000_0000);
      $display("reset values done");
      duty = 20 + ($random(seed) & 15);
      bus(1'b1, ADDR_PERIOD, PER);
      bus(1'b1, ADDR_DUTY, duty);
      bus(1'b1, ADDR_CTRL, 32'h0000_0001);
      bus(1'b1, ADDR_DUTY, 32'h0000_0005);
      bus(1'b0, ADDR_DUTY, 32'h0000_0000);
      repeat (2 * PER) @(posedge clk);
      nh = 0;
      nl = 0;
      nr = 0;
      p = hs;
      repeat (3 * PER) begin
         @(posedge clk);
         nh += hs;
         nl += ls;
         nr += hs & !p;
         p = hs;
      end
      chk("rises", nr, 3);
      chk("high time", nh, 3 * (duty - DR));
      chk("on time", nh + nl, 3 * (PER - DR - DF));
      $display("switching done");
      bus(1'b1, ADDR_CTRL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk("off", {hs, ls}, 0);
      chk("shoot", sc, 0);
      $display("disable done");
      end_of_test;
   end
endmodule
`default_nettype wire
